// file: dv/ppp_sva.sv
// ppp_sva: pin-level checks between programmer and device ends.
// assumes plain interface signals in the pclk domain.
`timescale 1ns/1ps
module ppp_sva #(
  parameter int         PROG_CYCLES = 200,
  parameter logic [7:0] SIG_1       = 8'h00,
  parameter logic [7:0] CAL_BYTE    = 8'h00
) (
  input wire logic       pclk,             // clock
  input wire logic       presetn,          // reset, active low
  input wire logic       load_action_bit1, // pin
  input wire logic       load_action_bit0, // pin
  input wire logic       byte_sel_a,       // pin
  input wire logic       load_strobe_clock,// pin
  input wire logic       wr_n,             // pin
  input wire logic       oe_n,             // pin
  input wire logic       ready_busy_out,   // pin
  input wire logic       host_data_oe,     // host bus enable
  input wire logic [7:0] dev_data,         // device bus value
  input wire logic       dev_data_oe,      // device bus enable
  input wire logic [7:0] data_bus          // resolved bus
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] cmd;
  logic [7:0] addr_lo;
  int         busy_cnt;
  wire  [1:0] xa    = {load_action_bit1, load_action_bit0};
  wire        armed = cmd == ppp_pkg::CMD_WR_FUSE ||
    cmd == ppp_pkg::CMD_WR_LOCK || (!byte_sel_a &&
    (cmd == ppp_pkg::CMD_WR_FLASH || cmd == ppp_pkg::CMD_WR_EE));
  wire        rd_ok = !oe_n && cmd == ppp_pkg::CMD_RD_SIG;
  // shadow of the device's command and low address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd     <= 8'h00;
      addr_lo <= 8'h00;
      busy_cnt <= 0;
    end else begin
      busy_cnt <= ready_busy_out ? 0 : busy_cnt + 1;
      if ($rose(load_strobe_clock) && !byte_sel_a) begin
        if (xa == ppp_pkg::XA_CMD) cmd <= data_bus;
        if (xa == ppp_pkg::XA_ADDR) addr_lo <= data_bus;
      end
    end
  end
  oe_follow_a: assert property (dev_data_oe == !oe_n)
    else $error("device bus enable differs from output enable");
  host_release_a: assert property (!oe_n |-> !host_data_oe)
    else $error("host drives bus during read");
  busy_start_a: assert property ($fell(wr_n) && ready_busy_out && armed
    |-> ##[1:3] !ready_busy_out) else $error("write strobe gave no busy");
  busy_len_a: assert property ($rose(ready_busy_out)
    |-> busy_cnt == PROG_CYCLES) else $error("busy length wrong");
  busy_hold_a: assert property (!ready_busy_out &&
    busy_cnt < PROG_CYCLES - 1 |=> !ready_busy_out)
    else $error("busy ended early");
  no_arm_a: assert property ($fell(wr_n) && ready_busy_out && !armed
    |=> ready_busy_out [*4]) else $error("unarmed write went busy");
  cal_read_a: assert property (rd_ok && $past(oe_n) == 1'b0 &&
    byte_sel_a |-> dev_data == CAL_BYTE) else $error("bad calibration");
  sig_read_a: assert property (rd_ok && $past(oe_n) == 1'b0 &&
    !byte_sel_a && addr_lo == 8'h01 |-> dev_data == SIG_1)
    else $error("bad signature byte");
  cover property ($fell(ready_busy_out));
  cover property ($fell(wr_n) && !armed);
  cover property (rd_ok && byte_sel_a);
endmodule // ppp_sva

// file: dv/tb_top.sv
// tb_top: apb-driven host joined to the device; table of orders.
// assumes the apb slave answers; a hung wait is ended by the watchdog.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  num_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  localparam int         PROG = 200;
  localparam logic [7:0] SIG1 = 8'h12;  // arbitrary value
  localparam logic [7:0] CAL  = 8'h9C;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, err_q;
  int          num_errors  = 0;
  int          comparisons = 0;
  // order word [15:0], expected read byte [23:16], check flag [24]
  logic [31:0] rows [41] = '{
    32'h4008, 32'hA504, 32'h0002, 32'h3C04, 32'h0012,
    32'h5A04, 32'h0022, 32'h2008, 32'hF004, 32'h0002,
    32'hFF04, 32'h0002, 32'h0408, 32'h01A5_0003,
    32'h013C_0033, 32'h015A_0023, 32'h01F0_0013, 32'h0808,
    32'h0100, {8'h01, SIG1, 16'h0003}, {8'h01, CAL, 16'h0013},
    32'h1008, 32'h7F00, 32'h1104, 32'h2214, 32'h0011,
    32'h0210, 32'h0002, 32'h0008, 32'h0002, 32'h0208,
    32'h0111_0003, 32'h0122_0013, 32'h1108,
    32'h0110, 32'h0500, 32'h7704, 32'h0001, 32'h0002,
    32'h0308, 32'h0177_0003};
  ppp_if link_if ();
  ppp_host ppp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
  ppp_device #(.FLASH_AW(10), .PROG_CYCLES(PROG), .SIG_1(SIG1),
    .CAL_BYTE(CAL)) ppp_device_inst (.pclk(pclk), .presetn(presetn),
    .link(link_if));
  ppp_sva #(.PROG_CYCLES(PROG), .SIG_1(SIG1), .CAL_BYTE(CAL)) ppp_sva_inst (
    .pclk(pclk), .presetn(presetn),
    .load_action_bit1(link_if.load_action_bit1),
    .load_action_bit0(link_if.load_action_bit0),
    .byte_sel_a(link_if.byte_sel_a),
    .load_strobe_clock(link_if.load_strobe_clock), .wr_n(link_if.wr_n),
    .oe_n(link_if.oe_n), .ready_busy_out(link_if.ready_busy_out),
    .host_data_oe(link_if.host_data_oe), .dev_data(link_if.dev_data),
    .dev_data_oe(link_if.dev_data_oe), .data_bus(link_if.data_bus));
  always #4 pclk = ~pclk;
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one pin action, then poll until the host is idle again
  task automatic order(input logic [15:0] o);
    apb(1'b1, ppp_pkg::OFS_ORDER, {16'h0000, o});
    do apb(1'b0, ppp_pkg::OFS_STATUS, 32'h0); while (q[0] !== 1'b0);
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ppp_pkg::OFS_STATUS, 32'h0);
    `CHK("status after reset", 2'b10, q[1:0])
    $display("test reset state done");
    foreach (rows[i]) begin
      order(rows[i][15:0]);
      if (rows[i][24]) `CHK("read byte", rows[i][23:16], q[15:8])
    end
    $display("test order table done");
    apb(1'b0, 8'h08, 32'h0);
    `CHK("unmapped error", 1'b1, err_q)
    `CHK("unmapped data", 32'h0, q)
    $display("test unmapped done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    order(16'h0408);
    order(16'h0003);
    `CHK("fuse after reset", 8'hFF, q[15:8])
    $display("test second reset done");
    report_and_stop();
  end
endmodule // tb_top

// file: rtl/ppp_device.sv
// ppp_device: device end of the parallel programming port with flash,
// eeprom, fuses, lock bits, signature and calibration storage.
// assumes all pins are synchronous to pclk and strobes last >= 2 cycles.
`timescale 1ns/1ps
module ppp_device #(
  parameter int         FLASH_AW    = 16,
  parameter int         FLASH_PW    = 7,
  parameter int         EE_AW       = 12,
  parameter int         EE_PW       = 3,
  parameter int         PROG_CYCLES = ppp_pkg::PROG_CYCLES,
  parameter logic [7:0] SIG_0       = 8'h5A,  // arbitrary value
  parameter logic [7:0] SIG_1       = 8'hA5,  // arbitrary value
  parameter logic [7:0] SIG_2       = 8'h3C,  // arbitrary value
  parameter logic [7:0] CAL_BYTE    = 8'h80,
  parameter logic [7:0] FUSE_LO_RST = 8'hFF,
  parameter logic [7:0] FUSE_HI_RST = 8'hFF,
  parameter logic [7:0] FUSE_EX_RST = 8'hFF,
  parameter logic [7:0] LOCK_RST    = 8'hFF
) (
  input wire logic pclk,     // clock, 125 MHz
  input wire logic presetn,  // async reset, active low
  ppp_if.dev       link      // pins towards the programmer
);
  // ---------------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------------
  if (FLASH_AW > 16 || FLASH_PW > 8 || FLASH_PW >= FLASH_AW ||
      EE_AW > 16 || EE_PW > 8 || EE_PW >= EE_AW ||
      PROG_CYCLES < (1 << FLASH_PW) + 1 ||
      PROG_CYCLES < (1 << EE_PW) + 1) begin : g_bad_param
    $error("ppp_device: unsupported parameter set");
  end

  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam int IW = (FLASH_PW > EE_PW) ? FLASH_PW : EE_PW;

  // ---------------------------------------------------------------------
  // strobe edges
  // ---------------------------------------------------------------------
  logic [2:0] rise;
  logic [2:0] fall;

  ppp_edge #(.W(3)) u_edge (
    .pclk     (pclk),
    .presetn  (presetn),
    .sig      ({link.load_strobe_clock, link.page_latch_strobe,
                link.wr_n}),
    .idle_lvl (3'b001),
    .rise     (rise),
    .fall     (fall)
  );

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  logic [7:0]    cmd;
  logic [7:0]    addr_lo;
  logic [7:0]    addr_hi;
  logic [7:0]    data_lo;
  logic [7:0]    data_hi;
  logic          armed;
  logic [CW-1:0] busy_cnt;
  logic          commit_fl;
  logic          commit_ee;
  logic [IW-1:0] commit_idx;
  logic [FLASH_AW-FLASH_PW-1:0] commit_fpage;
  logic [EE_AW-EE_PW-1:0]       commit_epage;
  logic [7:0]    fuse_lo;
  logic [7:0]    fuse_hi;
  logic [7:0]    fuse_ext;
  logic [7:0]    lock;
  logic [7:0]    dout;

  logic [15:0] flash_mem [2**FLASH_AW];
  logic [15:0] flash_buf [2**FLASH_PW];
  logic [7:0]  ee_mem    [2**EE_AW];
  logic [7:0]  ee_buf    [2**EE_PW];

  // ---------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------
  wire [1:0]  xa       = {link.load_action_bit1, link.load_action_bit0};
  wire        bs_a     = link.byte_sel_a;
  wire        bs_e     = link.byte_sel_ext;
  wire [7:0]  bus      = link.data_bus;
  wire        ld_pulse = rise[2];
  wire        pl_pulse = rise[1];
  wire        wr_pulse = fall[0];
  wire        ready    = (busy_cnt == '0);
  wire        ld_cmd   = ld_pulse && xa == ppp_pkg::XA_CMD && !bs_a;
  wire        ld_alo   = ld_pulse && xa == ppp_pkg::XA_ADDR && !bs_a;
  wire        ld_ahi   = ld_pulse && xa == ppp_pkg::XA_ADDR && bs_a;
  wire        ld_dlo   = ld_pulse && xa == ppp_pkg::XA_DATA && !bs_a;
  wire        ld_dhi   = ld_pulse && xa == ppp_pkg::XA_DATA && bs_a;
  wire        is_wfl   = (cmd == ppp_pkg::CMD_WR_FLASH);
  wire        is_wee   = (cmd == ppp_pkg::CMD_WR_EE);
  wire        bus_wcmd = bus == ppp_pkg::CMD_WR_FLASH ||
                         bus == ppp_pkg::CMD_WR_EE ||
                         bus == ppp_pkg::CMD_WR_FUSE ||
                         bus == ppp_pkg::CMD_WR_LOCK;
  wire [15:0] full_addr = {addr_hi, addr_lo};
  wire [FLASH_AW-1:0] fl_addr = full_addr[FLASH_AW-1:0];
  wire [EE_AW-1:0]    ee_addr = full_addr[EE_AW-1:0];
  wire [FLASH_PW-1:0] fl_word = addr_lo[FLASH_PW-1:0];
  wire [EE_PW-1:0]    ee_word = addr_lo[EE_PW-1:0];
  wire        latch_fl = pl_pulse && bs_a && is_wfl;
  wire        latch_ee = pl_pulse && is_wee;
  wire        wr_ok    = wr_pulse && armed && ready;
  wire        start_fl = wr_ok && !bs_a && is_wfl;
  wire        start_ee = wr_ok && !bs_a && is_wee;
  wire        wr_fuse  = wr_ok && cmd == ppp_pkg::CMD_WR_FUSE;
  wire        wr_lock  = wr_ok && cmd == ppp_pkg::CMD_WR_LOCK;
  wire        start    = start_fl || start_ee || wr_fuse || wr_lock;
  wire        sel_flo  = !bs_e && !bs_a;
  wire        sel_fhi  = !bs_e && bs_a;
  wire        sel_fex  = bs_e && !bs_a;
  wire [IW-1:0] last_idx = commit_fl ? IW'((1 << FLASH_PW) - 1)
                                     : IW'((1 << EE_PW) - 1);

  // ---------------------------------------------------------------------
  // command, address and data loads
  // ---------------------------------------------------------------------
  // values stay until reloaded, so repeated accesses need no reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd     <= ppp_pkg::CMD_NOP;
      addr_lo <= '0;
      addr_hi <= '0;
      data_lo <= ppp_pkg::BYTE_ERASED;
      data_hi <= ppp_pkg::BYTE_ERASED;
    end else begin
      if (ld_cmd) cmd <= bus;
      if (ld_alo) addr_lo <= bus;
      if (ld_ahi) addr_hi <= bus;
      if (ld_dlo) data_lo <= bus;
      if (ld_dhi) data_hi <= bus;
    end
  end

  // loading any non-write command drops write permission; a new write command restores it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (ld_cmd) begin
      armed <= bus_wcmd;
    end
  end

  // ---------------------------------------------------------------------
  // programming timer and page commit
  // ---------------------------------------------------------------------
  // the page is copied one entry per cycle, well inside the busy time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt     <= '0;
      commit_fl    <= 1'b0;
      commit_ee    <= 1'b0;
      commit_idx   <= '0;
      commit_fpage <= '0;
      commit_epage <= '0;
    end else if (start) begin
      busy_cnt     <= CW'(PROG_CYCLES);
      commit_fl    <= start_fl;
      commit_ee    <= start_ee;
      commit_idx   <= '0;
      commit_fpage <= fl_addr[FLASH_AW-1:FLASH_PW];
      commit_epage <= ee_addr[EE_AW-1:EE_PW];
    end else begin
      if (!ready) busy_cnt <= busy_cnt - 1'b1;
      if (commit_fl || commit_ee) begin
        commit_idx <= commit_idx + 1'b1;
        if (commit_idx == last_idx) begin
          commit_fl <= 1'b0;
          commit_ee <= 1'b0;
        end
      end
    end
  end

  // arrays hold no reset: contents survive like nonvolatile storage
  always_ff @(posedge pclk) begin
    if (latch_fl) flash_buf[fl_word] <= {data_hi, data_lo};
    if (latch_ee) ee_buf[ee_word] <= data_lo;
    if (commit_fl)
      flash_mem[{commit_fpage, commit_idx[FLASH_PW-1:0]}] <=
        flash_buf[commit_idx[FLASH_PW-1:0]];
    if (commit_ee)
      ee_mem[{commit_epage, commit_idx[EE_PW-1:0]}] <=
        ee_buf[commit_idx[EE_PW-1:0]];
  end

  // ---------------------------------------------------------------------
  // fuses and lock bits
  // ---------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_lo  <= FUSE_LO_RST;
      fuse_hi  <= FUSE_HI_RST;
      fuse_ext <= FUSE_EX_RST;
      lock     <= LOCK_RST;
    end else begin
      if (wr_fuse && sel_flo) fuse_lo  <= data_lo;
      if (wr_fuse && sel_fhi) fuse_hi  <= data_lo;
      if (wr_fuse && sel_fex) fuse_ext <= data_lo;
      // a one never erases a lock bit; only reset sets them back to LOCK_RST
      if (wr_lock) lock <= lock & data_lo;
    end
  end

  // ---------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------
  wire [15:0] fl_rd  = flash_mem[fl_addr];
  wire [7:0]  fl_byte = bs_a ? fl_rd[15:8] : fl_rd[7:0];
  wire [7:0]  fz_byte = sel_flo ? fuse_lo :
                        sel_fex ? fuse_ext :
                        bs_e    ? fuse_hi : lock;
  wire [7:0]  sig_byte = addr_lo == 8'h00 ? SIG_0 :
                         addr_lo == 8'h01 ? SIG_1 :
                         addr_lo <  ppp_pkg::SIG_COUNT ? SIG_2 :
                         ppp_pkg::BYTE_ERASED;
  wire [7:0]  rd_byte =
    cmd == ppp_pkg::CMD_RD_FLASH ? fl_byte :
    cmd == ppp_pkg::CMD_RD_EE    ? ee_mem[ee_addr] :
    cmd == ppp_pkg::CMD_RD_FUSE  ? fz_byte :
    cmd == ppp_pkg::CMD_RD_SIG   ? (bs_a ? CAL_BYTE : sig_byte)
                                 : ppp_pkg::BYTE_ERASED;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= ppp_pkg::BYTE_ERASED;
    end else begin
      dout <= rd_byte;
    end
  end

  assign link.dev_data       = dout;
  assign link.dev_data_oe    = !link.oe_n;
  assign link.ready_busy_out = ready;

endmodule // ppp_device

// file: rtl/ppp_edge.sv
// ppp_edge: rising and falling edge pulses of synchronous pin levels.
// assumes inputs are already synchronous to pclk.
`timescale 1ns/1ps
module ppp_edge #(
  parameter int W = 1
) (
  input  wire logic         pclk,     // clock
  input  wire logic         presetn,  // async reset, active low
  input  wire logic [W-1:0] sig,      // sampled levels
  input  wire logic [W-1:0] idle_lvl, // level assumed at reset release
  output      logic [W-1:0] rise,     // one-cycle rising pulse
  output      logic [W-1:0] fall      // one-cycle falling pulse
);
  logic [W-1:0] prev;
  logic         primed;

  // before the first real sample, edges are judged against idle_lvl
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev   <= '0;
      primed <= 1'b0;
    end else begin
      prev   <= sig;
      primed <= 1'b1;
    end
  end

  wire [W-1:0] ref_lvl = primed ? prev : idle_lvl;
  assign rise = sig & ~ref_lvl;
  assign fall = ~sig & ref_lvl;
endmodule // ppp_edge

// file: rtl/ppp_host.sv
// ppp_host: programmer end; software issues one pin action per order.
// assumes apb master in the pclk domain; orders are taken only when idle.
`timescale 1ns/1ps
module ppp_host (
  input  wire logic        pclk,     // clock, 125 MHz
  input  wire logic        presetn,  // async reset, active low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb write
  input  wire logic [7:0]  paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output      logic [31:0] prdata,   // apb read data
  output      logic        pready,   // apb ready
  output      logic        pslverr,  // apb error, unmapped address
  ppp_if.host              link      // pins towards the device
);
  // ---------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------
  ppp_pkg::ppp_host_state_t state;
  logic [15:0] order;
  logic [7:0]  rd_byte;
  logic [7:0]  tcnt;

  wire       access   = psel && penable;
  wire       hit_ord  = (paddr == ppp_pkg::OFS_ORDER);
  wire       hit_st   = (paddr == ppp_pkg::OFS_STATUS);
  wire       idle     = (state == ppp_pkg::PPP_IDLE);
  wire       take     = access && pwrite && hit_ord && idle;
  wire [1:0] act      = order[ppp_pkg::ORD_ACT_LSB +: 2];
  wire       tdone    = (tcnt == '0);
  wire [31:0] status  = {16'h0000, rd_byte, 6'h00,
                         link.ready_busy_out, !idle};

  wire [31:0] next_prdata = hit_ord ? {16'h0000, order} :
                            hit_st  ? status : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = access && !hit_ord && !hit_st;

  // read data is caught in the setup cycle so it stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------------
  // pin sequencer
  // ---------------------------------------------------------------------
  localparam logic [7:0] SETUP_T = 8'(ppp_pkg::SETUP_CYC - 1);
  localparam logic [7:0] PULSE_T = 8'(ppp_pkg::PULSE_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ppp_pkg::PPP_IDLE;
      tcnt  <= '0;
    end else begin
      if (!tdone) tcnt <= tcnt - 1'b1;
      case (state)
        ppp_pkg::PPP_IDLE: begin
          if (take) begin
            state <= ppp_pkg::PPP_SETUP;
            tcnt  <= SETUP_T;
          end
        end
        ppp_pkg::PPP_SETUP: begin
          if (tdone) begin
            state <= ppp_pkg::PPP_PULSE;
            tcnt  <= PULSE_T;
          end
        end
        ppp_pkg::PPP_PULSE: begin
          if (tdone) begin
            state <= ppp_pkg::PPP_HOLD;
            tcnt  <= SETUP_T;
          end
        end
        ppp_pkg::PPP_HOLD: begin
          // busy has had time to fall by now, so the wait cannot slip past
          if (tdone) state <= ppp_pkg::PPP_WAIT;
        end
        ppp_pkg::PPP_WAIT: begin
          if (link.ready_busy_out) state <= ppp_pkg::PPP_IDLE;
        end
        default: state <= ppp_pkg::PPP_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      order   <= {8'h00, 2'b00, 2'b00, ppp_pkg::XA_IDLE, ppp_pkg::ACT_LOAD};
      rd_byte <= '0;
    end else begin
      if (take) order <= pwdata[15:0];
      if (state == ppp_pkg::PPP_PULSE && tdone && act == ppp_pkg::ACT_READ)
        rd_byte <= link.data_bus;
    end
  end

  wire pulsing = (state == ppp_pkg::PPP_PULSE);

  assign link.load_action_bit1  = order[ppp_pkg::ORD_XA_LSB + 1];
  assign link.load_action_bit0  = order[ppp_pkg::ORD_XA_LSB];
  assign link.byte_sel_a        = order[ppp_pkg::ORD_BSA_BIT];
  assign link.byte_sel_ext      = order[ppp_pkg::ORD_BSE_BIT];
  assign link.host_data         = order[ppp_pkg::ORD_DATA_LSB +: 8];
  assign link.host_data_oe      = !idle && act != ppp_pkg::ACT_READ;
  assign link.load_strobe_clock = pulsing && act == ppp_pkg::ACT_LOAD;
  assign link.page_latch_strobe = pulsing && act == ppp_pkg::ACT_LATCH;
  assign link.wr_n              = !(pulsing && act == ppp_pkg::ACT_WRITE);
  assign link.oe_n              = !(pulsing && act == ppp_pkg::ACT_READ);

endmodule // ppp_host

// file: rtl/ppp_if.sv
// ppp_if: pins between programmer and device.
// the shared data bus is resolved here from the two output enables.
`timescale 1ns/1ps
interface ppp_if;
  logic       load_action_bit1;
  logic       load_action_bit0;
  logic       byte_sel_a;
  logic       byte_sel_ext;
  logic       page_latch_strobe;
  logic       load_strobe_clock;
  logic       wr_n;
  logic       oe_n;
  logic       ready_busy_out;
  logic [7:0] host_data;
  logic       host_data_oe;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  wire  [7:0] data_bus;

  // undriven bus reads as pulled high
  assign data_bus = dev_data_oe  ? dev_data  :
                    host_data_oe ? host_data : 8'hFF;

  modport dev (
    input  load_action_bit1, load_action_bit0, byte_sel_a, byte_sel_ext,
    input  page_latch_strobe, load_strobe_clock, wr_n, oe_n, data_bus,
    output ready_busy_out, dev_data, dev_data_oe
  );
  modport host (
    output load_action_bit1, load_action_bit0, byte_sel_a, byte_sel_ext,
    output page_latch_strobe, load_strobe_clock, wr_n, oe_n,
    output host_data, host_data_oe,
    input  data_bus, ready_busy_out
  );
endinterface : ppp_if

// file: rtl/ppp_pkg.sv
// ppp_pkg: constants shared by both ends of the parallel programming port.
// assumes a single 125 MHz clock on both ends.
package ppp_pkg;

  // ---------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_NS  = 3700000;  // least page programming time
  localparam int PROG_CYCLES   =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_NS      = 250;      // least strobe width
  localparam int PULSE_CYC     =
    (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_NS      = 67;       // select setup and hold
  localparam int SETUP_CYC     =
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // load action coding and command bytes
  // ---------------------------------------------------------------------
  localparam logic [1:0] XA_ADDR = 2'h0;
  localparam logic [1:0] XA_DATA = 2'h1;
  localparam logic [1:0] XA_CMD  = 2'h2;
  localparam logic [1:0] XA_IDLE = 2'h3;

  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;

  localparam logic [7:0] BYTE_ERASED  = 8'hFF;
  localparam logic [7:0] SIG_COUNT    = 8'h03;

  // ---------------------------------------------------------------------
  // controller registers on apb
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_ORDER  = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;

  localparam int ORD_ACT_LSB  = 0;   // two bits: action
  localparam int ORD_XA_LSB   = 2;   // two bits: load action
  localparam int ORD_BSA_BIT  = 4;
  localparam int ORD_BSE_BIT  = 5;
  localparam int ORD_DATA_LSB = 8;   // eight bits: bus byte
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_RDY_BIT   = 1;
  localparam int ST_DATA_LSB  = 8;

  localparam logic [1:0] ACT_LOAD  = 2'h0;
  localparam logic [1:0] ACT_LATCH = 2'h1;
  localparam logic [1:0] ACT_WRITE = 2'h2;
  localparam logic [1:0] ACT_READ  = 2'h3;

  typedef enum logic [2:0] {
    PPP_IDLE  = 3'h0,
    PPP_SETUP = 3'h1,
    PPP_PULSE = 3'h3,
    PPP_HOLD  = 3'h2,
    PPP_WAIT  = 3'h6
  } ppp_host_state_t;

endpackage
